// >>> design/ioeps_pkg.sv
// Constants for the egress event-selection block of the I/O agent monitor.
// Assumes one uncore clock; used by the selector and its increment helper.
package ioeps_pkg;
   // ------------------------------------------------------------
   // Control field layout
   // ------------------------------------------------------------
   localparam int EVT_LSB = 0;
   localparam int EVT_MSB = 7;
   localparam int UMASK_LSB = 8;
   localparam int UMASK_MSB = 15;
   localparam int CTL_W = 16;
   localparam logic [7:0] UMASK_ANY = 8'h00;
   // ------------------------------------------------------------
   // Event codes
   // ------------------------------------------------------------
   localparam logic [7:0] EV_DRS_INS = 8'h02;
   localparam logic [7:0] EV_NCB_INS = 8'h03;
   localparam logic [7:0] EV_NCS_INS = 8'h04;
   localparam logic [7:0] EV_DRS_FULL = 8'h05;
   localparam logic [7:0] EV_NCB_FULL = 8'h06;
   localparam logic [7:0] EV_NCS_FULL = 8'h07;
   localparam logic [7:0] EV_DRS_OCC = 8'h08;
   localparam logic [7:0] EV_NCB_OCC = 8'h09;
   localparam logic [7:0] EV_NCS_OCC = 8'h0a;
   localparam logic [7:0] EV_ACK_INS = 8'h0b;
   localparam logic [7:0] EV_OUT_OCC = 8'h0c;
   localparam logic [7:0] EV_SW_NCB = 8'h0d;
   localparam logic [7:0] EV_SW_NCS = 8'h0e;
   localparam logic [7:0] EV_AD_STALL = 8'h1a;
   localparam logic [7:0] EV_BL_STALL = 8'h1b;
   // ------------------------------------------------------------
   // Sizes and reset values
   // ------------------------------------------------------------
   localparam int NUM_CTR = 2;
   localparam int OCC_W = 8;
   localparam int CTR_W = 48;
   localparam logic [47:0] CTR_RST = 48'h0;
endpackage

// >>> design/ioeps_evt_if.sv
// Carrier of per-cycle event sources from the egress queues to the decoder.
// Assumes all sources are synchronous to the selector clock.
`timescale 1ns/100ps
interface ioeps_evt_if #(parameter int OCC_W = 8);
   logic ackIns;
   logic [2:0] blIns;
   logic [2:0] blFull;
   logic [OCC_W-1:0] blOcc [3];
   logic adStall;
   logic blStall;
   logic [1:0] swIns;
   logic [OCC_W-1:0] outOcc;
   modport src (output ackIns, blIns, blFull, blOcc, adStall, blStall, swIns, outOcc);
   modport dec (input ackIns, blIns, blFull, blOcc, adStall, blStall, swIns, outOcc);
endinterface

// >>> design/ioeps_incr.sv
// Maps one event code and umask onto a per-cycle increment amount.
// Assumes registered event sources arriving over the carrier interface.
`timescale 1ns/100ps
module ioeps_incr
   import ioeps_pkg::*;
#(
   parameter int OCC_W = 8
) (
   // Event sources
   ioeps_evt_if.dec evt,
   // Selection
   input wire logic [7:0] evtCode,
   input wire logic [7:0] umask,
   // Result
   output logic [OCC_W-1:0] incr
);
   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   function automatic logic [OCC_W-1:0] bit1(input logic b);
      bit1 = {{(OCC_W-1){1'b0}}, b};
   endfunction

   logic umaskOk;
   // No qualifier defined for these events; zero umask or any bit set passes
   assign umaskOk = (umask == UMASK_ANY) || (|umask);

   // Select the matching increment; unknown codes add nothing
   always_comb begin
      incr = '0;
      case (evtCode)
         EV_ACK_INS: incr = bit1(evt.ackIns);
         EV_DRS_FULL: incr = bit1(evt.blFull[0]);
         EV_NCB_FULL: incr = bit1(evt.blFull[1]);
         EV_NCS_FULL: incr = bit1(evt.blFull[2]);
         EV_DRS_INS: incr = bit1(evt.blIns[0]);
         EV_NCB_INS: incr = bit1(evt.blIns[1]);
         EV_NCS_INS: incr = bit1(evt.blIns[2]);
         EV_DRS_OCC: incr = evt.blOcc[0];
         EV_NCB_OCC: incr = evt.blOcc[1];
         EV_NCS_OCC: incr = evt.blOcc[2];
         EV_AD_STALL: incr = bit1(evt.adStall);
         EV_BL_STALL: incr = bit1(evt.blStall);
         EV_SW_NCB: incr = bit1(evt.swIns[0]);
         EV_SW_NCS: incr = bit1(evt.swIns[1]);
         EV_OUT_OCC: incr = evt.outOcc;
         default: incr = '0;
      endcase
      if (!umaskOk) begin
         incr = '0;
      end
   end
endmodule

// >>> design/ioeps_top.sv
// Event selection and counting for counters 0 and 1 of the I/O agent monitor.
// Assumes event sources on the same clock; controls come from monitor logic.
`timescale 1ns/100ps
// Contract
// - Code 0x0b counts each acknowledge egress queue allocation.
// - Codes 0x05-0x07 count full cycles of coherent, bypass, standard data queues.
// - Codes 0x02-0x04 count inserts into coherent, bypass, standard data queues.
// - Codes 0x08-0x0a add occupancy of coherent, bypass, standard data queues.
// - Code 0x1a counts request stalls for lack of address egress credit.
// - Code 0x1b counts data stalls for lack of data egress credit.
// - Codes 0x0d, 0x0e count bypass and standard requests issued to switch.
// - Code 0x0c adds outstanding outbound request count every cycle.
// - Control carries umask in bits 15:8 beside the event code.
module ioeps_top
   import ioeps_pkg::*;
#(
   parameter int OCC_W_P = OCC_W,
   parameter int CTR_W_P = CTR_W
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Counter controls, one per counter
   input wire logic [CTL_W-1:0] ctl0,
   input wire logic [CTL_W-1:0] ctl1,
   input wire logic ctrClear,
   // Event sources
   input wire logic ackIns,
   input wire logic [2:0] blIns,
   input wire logic [2:0] blFull,
   input wire logic [OCC_W_P-1:0] drsOcc,
   input wire logic [OCC_W_P-1:0] ncbOcc,
   input wire logic [OCC_W_P-1:0] ncsOcc,
   input wire logic adStall,
   input wire logic blStall,
   input wire logic [1:0] swIns,
   input wire logic [OCC_W_P-1:0] outOcc,
   // Counter values
   output logic [CTR_W_P-1:0] count0_q,
   output logic [CTR_W_P-1:0] count1_q
);
   // ------------------------------------------------------------
   // Pipeline timing
   // ------------------------------------------------------------
   // Edge N samples each source into the capture stage
   // Edge N+1 adds the captured value into the selected counter
   // So a count trails its event by two edges, never more
   // Controls act on the edge they are seen; they are levels from monitor logic
   // Clear and reset beat any increment landing in the same cycle
   // The extra stage costs a cycle of latency but eases the long route
   // Umask reaches the helper but qualifies nothing for these events

   // ------------------------------------------------------------
   // Decode helpers
   // ------------------------------------------------------------
   // Event code field of one counter control
   function automatic logic [7:0] ctlCode(input logic [CTL_W-1:0] c);
      ctlCode = c[EVT_MSB:EVT_LSB];
   endfunction

   // Qualifier field of one counter control
   function automatic logic [7:0] ctlUmask(input logic [CTL_W-1:0] c);
      ctlUmask = c[UMASK_MSB:UMASK_LSB];
   endfunction

   // True for the codes routed here; both counters share this decode
   function automatic logic evtKnown(input logic [7:0] code);
      case (code)
         EV_ACK_INS: evtKnown = 1'b1;
         EV_DRS_FULL: evtKnown = 1'b1;
         EV_NCB_FULL: evtKnown = 1'b1;
         EV_NCS_FULL: evtKnown = 1'b1;
         EV_DRS_INS: evtKnown = 1'b1;
         EV_NCB_INS: evtKnown = 1'b1;
         EV_NCS_INS: evtKnown = 1'b1;
         EV_DRS_OCC: evtKnown = 1'b1;
         EV_NCB_OCC: evtKnown = 1'b1;
         EV_NCS_OCC: evtKnown = 1'b1;
         EV_AD_STALL: evtKnown = 1'b1;
         EV_BL_STALL: evtKnown = 1'b1;
         EV_SW_NCB: evtKnown = 1'b1;
         EV_SW_NCS: evtKnown = 1'b1;
         EV_OUT_OCC: evtKnown = 1'b1;
         default: evtKnown = 1'b0;
      endcase
   endfunction

   // ------------------------------------------------------------
   // Source capture
   // ------------------------------------------------------------
   ioeps_evt_if #(.OCC_W(OCC_W_P)) evtBus ();

   // Acknowledge allocation strobe
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         evtBus.ackIns <= 1'b0;
      end else begin
         evtBus.ackIns <= ackIns;
      end
   end

   // Data-block insert strobes, coherent response in bit 0
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         evtBus.blIns <= '0;
      end else begin
         evtBus.blIns <= blIns;
      end
   end

   // Data-block full flags, same bit order
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         evtBus.blFull <= '0;
      end else begin
         evtBus.blFull <= blFull;
      end
   end

   // Data-block occupancies, reset to empty queues
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         evtBus.blOcc[0] <= '0;
         evtBus.blOcc[1] <= '0;
         evtBus.blOcc[2] <= '0;
      end else begin
         evtBus.blOcc[0] <= drsOcc;
         evtBus.blOcc[1] <= ncbOcc;
         evtBus.blOcc[2] <= ncsOcc;
      end
   end

   // Address-channel credit stall toward the ring agent
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         evtBus.adStall <= 1'b0;
      end else begin
         evtBus.adStall <= adStall;
      end
   end

   // Data-block credit stall toward the ring agent
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         evtBus.blStall <= 1'b0;
      end else begin
         evtBus.blStall <= blStall;
      end
   end

   // Switch request strobes, bypass class in bit 0
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         evtBus.swIns <= '0;
      end else begin
         evtBus.swIns <= swIns;
      end
   end

   // Outstanding outbound requests to the switch
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         evtBus.outOcc <= '0;
      end else begin
         evtBus.outOcc <= outOcc;
      end
   end

   // ------------------------------------------------------------
   // Per-counter selection and accumulation
   // ------------------------------------------------------------
   // Only counters 0 and 1 exist here, so these events cannot land elsewhere
   logic [CTL_W-1:0] ctl [NUM_CTR];
   logic [CTR_W_P-1:0] cnt_q [NUM_CTR];

   // Controls gathered into an array so one loop serves both counters
   assign ctl[0] = ctl0;
   assign ctl[1] = ctl1;

   genvar g;
   generate
      for (g = 0; g < NUM_CTR; g++) begin : gCtr
         logic [7:0] code;
         logic [7:0] qual;
         logic known;
         logic [OCC_W_P-1:0] inc;
         logic [CTR_W_P-1:0] cnt_d;

         // Split this counter's control into its two fields
         assign code = ctlCode(ctl[g]);
         assign qual = ctlUmask(ctl[g]);
         assign known = evtKnown(code);

         // Route the selected source onto one increment
         ioeps_incr #(.OCC_W(OCC_W_P)) uIncr (
            .evt(evtBus.dec),
            .evtCode(code),
            .umask(qual),
            .incr(inc)
         );

         // Unknown codes hold here as well, whatever the helper returns
         // Wraps silently at the counter width
         assign cnt_d = known ? CTR_W_P'(cnt_q[g] + CTR_W_P'(inc)) : cnt_q[g];

         // Clear and reset share the zero value and beat counting
         always_ff @(posedge clk) begin
            if (!reset_n || ctrClear) begin
               cnt_q[g] <= CTR_W_P'(CTR_RST);
            end else begin
               cnt_q[g] <= cnt_d;
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // Counters are flops already, so no extra output stage
   assign count0_q = cnt_q[0];
   assign count1_q = cnt_q[1];
endmodule

// >>> bench/ioeps_assertions.sv
// Port checker for the egress event selector.
// Assumes it is bound onto ioeps_top, one clock domain.
`timescale 1ns/100ps
module ioeps_assertions
   import ioeps_pkg::*;
#(parameter int OCC_W_P = 8, parameter int CTR_W_P = 48) (
   // Clock, reset and controls
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [CTL_W-1:0] ctl0,
   input wire logic [CTL_W-1:0] ctl1,
   input wire logic ctrClear,
   // Event sources
   input wire logic ackIns,
   input wire logic [2:0] blIns,
   input wire logic [2:0] blFull,
   input wire logic [OCC_W_P-1:0] drsOcc,
   input wire logic [OCC_W_P-1:0] ncbOcc,
   input wire logic [OCC_W_P-1:0] ncsOcc,
   input wire logic adStall,
   input wire logic blStall,
   input wire logic [1:0] swIns,
   input wire logic [OCC_W_P-1:0] outOcc,
   // Counter values
   input wire logic [CTR_W_P-1:0] count0_q,
   input wire logic [CTR_W_P-1:0] count1_q
);
   // ------------------------------
   // Expected step per code
   // ------------------------------
   logic [OCC_W_P-1:0] v [32];
   logic [OCC_W_P-1:0] i0;
   logic [OCC_W_P-1:0] i1;
   // Gaps and codes above 0x1f stay zero
   always_comb begin
      v = '{default: '0};
      v[5'h02] = OCC_W_P'(blIns[0]);
      v[5'h03] = OCC_W_P'(blIns[1]);
      v[5'h04] = OCC_W_P'(blIns[2]);
      v[5'h05] = OCC_W_P'(blFull[0]);
      v[5'h06] = OCC_W_P'(blFull[1]);
      v[5'h07] = OCC_W_P'(blFull[2]);
      v[5'h08] = drsOcc;
      v[5'h09] = ncbOcc;
      v[5'h0a] = ncsOcc;
      v[5'h0b] = OCC_W_P'(ackIns);
      v[5'h0c] = outOcc;
      v[5'h0d] = OCC_W_P'(swIns[0]);
      v[5'h0e] = OCC_W_P'(swIns[1]);
      v[5'h1a] = OCC_W_P'(adStall);
      v[5'h1b] = OCC_W_P'(blStall);
   end
   // Umask deliberately ignored
   assign i0 = (ctl0[7:5] == 3'h0) ? v[ctl0[4:0]] : '0;
   assign i1 = (ctl1[7:5] == 3'h0) ? v[ctl1[4:0]] : '0;
   // ------------------------------
   // Properties
   // ------------------------------
   // Two quiet cycles, so a clear or a code change cannot blur the step
   sequence calm(logic [7:0] lo, logic [7:0] hi);
      !ctrClear ##1 !ctrClear && $stable(ctl0) && $stable(ctl1) &&
         ctl0[7:0] >= lo && ctl0[7:0] <= hi;
   endsequence
   property step(logic [7:0] lo, logic [7:0] hi);
      @(posedge clk) disable iff (!reset_n)
      calm(lo, hi) |=> count0_q == $past(count0_q) + CTR_W_P'($past(i0, 2));
   endproperty
   ack_count_a: assert property (step(8'h0b, 8'h0b)) else $error("ack step wrong");
   full_count_a: assert property (step(8'h05, 8'h07)) else $error("full step wrong");
   insert_count_a: assert property (step(8'h02, 8'h04)) else $error("ins step wrong");
   occ_sum_a: assert property (step(8'h08, 8'h0a)) else $error("occ step wrong");
   ad_stall_a: assert property (step(8'h1a, 8'h1a)) else $error("ad step wrong");
   bl_stall_a: assert property (step(8'h1b, 8'h1b)) else $error("bl step wrong");
   switch_req_a: assert property (step(8'h0d, 8'h0e)) else $error("sw step wrong");
   out_occ_a: assert property (step(8'h0c, 8'h0c)) else $error("out step wrong");
   unknown_hold_a: assert property (step(8'h1c, 8'hff)) else $error("no hold");
   second_ctr_a: assert property (@(posedge clk) disable iff (!reset_n)
      calm(8'h00, 8'hff) |=> count1_q == $past(count1_q) + CTR_W_P'($past(i1, 2)))
      else $error("counter one step wrong");
   clear_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
      ctrClear |=> count0_q == '0 && count1_q == '0) else $error("clear missed");
endmodule
bind ioeps_top ioeps_assertions #(.OCC_W_P(OCC_W_P), .CTR_W_P(CTR_W_P)) u_chk (
   .clk(clk), .reset_n(reset_n), .ctl0(ctl0), .ctl1(ctl1), .ctrClear(ctrClear),
   .ackIns(ackIns), .blIns(blIns), .blFull(blFull), .drsOcc(drsOcc), .ncbOcc(ncbOcc),
   .ncsOcc(ncsOcc), .adStall(adStall), .blStall(blStall), .swIns(swIns),
   .outOcc(outOcc), .count0_q(count0_q), .count1_q(count1_q));

// >>> bench/ioeps_src_model.sv
// Egress queue and tracker model feeding the selector.
// Assumes the bench sets a pattern just after each clock edge.
`timescale 1ns/100ps
module ioeps_src_model (
   // Clock and pattern
   input wire logic clk,
   input wire logic [10:0] en,
   input wire logic [7:0] lvl,
   // Event sources
   output logic ackIns,
   output logic [2:0] blIns,
   output logic [2:0] blFull,
   output logic [7:0] drsOcc,
   output logic [7:0] ncbOcc,
   output logic [7:0] ncsOcc,
   output logic adStall,
   output logic blStall,
   output logic [1:0] swIns,
   output logic [7:0] outOcc
);
   logic [10:0] enQ = 11'h0;
   logic [7:0] lvlQ = 8'h0;
   // Registered, so sources change only on the edge
   always @(posedge clk) begin
      enQ <= en;
      lvlQ <= lvl;
   end
   // Occupancy only while traffic flows; the sum wraps at 8 bits
   assign {swIns, blStall, adStall, blFull, blIns, ackIns} = enQ;
   assign drsOcc = (|enQ) ? lvlQ : 8'h0;
   assign ncbOcc = (|enQ) ? lvlQ + 8'h1 : 8'h0;
   assign ncsOcc = (|enQ) ? lvlQ + 8'h2 : 8'h0;
   assign outOcc = (|enQ) ? lvlQ + 8'h3 : 8'h0;
endmodule

// >>> bench/io_egress_perf_event_select_test.sv
// Self-checking bench for the egress event selector.
// Assumes the source model and the bound checker.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin errors++; \
   $display("wrong value %s exp %0h got %0h", nm, ex, got); end end
module io_egress_perf_event_select_test;
   import ioeps_pkg::*;
   typedef struct {logic [7:0] code; logic [10:0] en; logic [7:0] inc;} ioeps_row_s;
   // -------------------------
   // Stimulus and state
   // -------------------------
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic ctrClear = 1'b0;
   logic [15:0] ctl0 = 16'h0;
   logic [15:0] ctl1 = 16'h0;
   logic [10:0] en = 11'h0;
   logic [7:0] lvl = 8'h5;
   logic [47:0] count0;
   logic [47:0] count1;
   logic ack, adS, blS;
   logic [2:0] blI, blF;
   logic [1:0] sw;
   logic [7:0] oD, oB, oS, oO;
   int errors = 0;
   int compares = 0;
   int cycles = 0;
   // Per-cycle step with lvl 5; single events see occupancy too
   ioeps_row_s rows [18] = '{'{8'h0b, 11'h001, 8'h1}, '{8'h02, 11'h002, 8'h1},
      '{8'h03, 11'h004, 8'h1}, '{8'h04, 11'h008, 8'h1}, '{8'h05, 11'h010, 8'h1},
      '{8'h06, 11'h020, 8'h1}, '{8'h07, 11'h040, 8'h1}, '{8'h1a, 11'h080, 8'h1},
      '{8'h1b, 11'h100, 8'h1}, '{8'h0d, 11'h200, 8'h1}, '{8'h0e, 11'h400, 8'h1},
      '{8'h08, 11'h7ff, 8'h5}, '{8'h09, 11'h7ff, 8'h6}, '{8'h0a, 11'h7ff, 8'h7},
      '{8'h0c, 11'h7ff, 8'h8}, '{8'h1c, 11'h7ff, 8'h0}, '{8'h00, 11'h7ff, 8'h0},
      '{8'hff, 11'h7ff, 8'h0}};
   always #2 clk = ~clk;
   ioeps_src_model u_src (.clk(clk), .en(en), .lvl(lvl), .ackIns(ack), .blIns(blI),
      .blFull(blF), .drsOcc(oD), .ncbOcc(oB), .ncsOcc(oS), .adStall(adS), .blStall(blS),
      .swIns(sw), .outOcc(oO));
   ioeps_top u_dut (.clk(clk), .reset_n(reset_n), .ctl0(ctl0), .ctl1(ctl1),
      .ctrClear(ctrClear), .ackIns(ack), .blIns(blI), .blFull(blF), .drsOcc(oD),
      .ncbOcc(oB), .ncsOcc(oS), .adStall(adS), .blStall(blS), .swIns(sw), .outOcc(oO),
      .count0_q(count0), .count1_q(count1));
   // -------------------------
   // Tasks
   // -------------------------
   task automatic stop_test;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Clear, then n cycles of pattern; odd umask on counter 0 must not matter
   task automatic run(input logic [7:0] code, input logic [10:0] pat, input int n);
      ctl0 = {8'ha5, code};
      ctl1 = {8'h00, code};
      ctrClear = 1'b1;
      @(posedge clk) #1;
      ctrClear = 1'b0;
      en = pat;
      repeat (n) @(posedge clk);
      #1 en = 11'h0;
      repeat (4) @(posedge clk);
      #1;
   endtask
   // Hang guard, run needs about 300 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         errors++;
         stop_test();
      end
   end
   initial begin
      repeat (5) @(posedge clk);
      #1 reset_n = 1'b1;
      // Only counters 0 and 1 are programmed
      foreach (rows[i]) begin
         run(rows[i].code, rows[i].en, 10);
         `CHK("count0", 48'(rows[i].inc) * 10, count0)
         `CHK("count1", 48'(rows[i].inc) * 10, count1)
      end
      // Full-scale occupancy, then a clear and a reset amid traffic
      lvl = 8'hff;
      run(8'h08, 11'h7ff, 4);
      `CHK("max occ", 48'h3fc, count0)
      en = 11'h7ff;
      ctl1 = 16'h0000;
      repeat (6) @(posedge clk);
      #1 ctrClear = 1'b1;
      `CHK("busy", 48'h7f8, count0)
      `CHK("hold", 48'h3fc, count1)
      @(posedge clk) #1;
      `CHK("clear", 48'h0, count0)
      ctrClear = 1'b0;
      repeat (3) @(posedge clk);
      #1 reset_n = 1'b0;
      @(posedge clk) #1;
      `CHK("reset", 48'h0, count1)
      `CHK("reset", 48'h0, count0)
      // Release amid traffic: no stray step, then counting resumes
      reset_n = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      `CHK("resume", 48'h1fe, count0)
      stop_test();
   end
endmodule
